// ==== hw/dual_prescaled_down_counters.sv ====
// ----------------------------------------------------------------
// Dual prescaled down counters, AHB-Lite slave
// ----------------------------------------------------------------
module dual_prescaled_down_counters (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Pins
	input  wire logic        extTimerInputLine, // Asynchronous pin
	output logic             timerOutputPin,
	// Interrupts
	output logic             firstTimerIrq,
	output logic             secondTimerIrq,
	output logic             irq,
	// Low-power status
	output logic             cpuClockEn          // Low while halted or stopped
);

	// ----------------------------------------------------------------
	// Bus address phase capture
	// ----------------------------------------------------------------
	logic       wrPend_q;      // Write data phase pending
	logic       rdPend_q;
	logic [7:0] addr_q;
	logic       wrAct;
	logic       rdAct;

	logic [7:0] ctrl_q;
	logic [7:0] mode_q;
	logic [7:0] load0_q;
	logic [7:0] load1_q;
	logic [5:0] pre0_q;
	logic [5:0] pre1_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [1:0] pwr_q;
	logic [31:0] rdata_q;

	// Per-timer pulses from writes
	logic [1:0] runSet;
	logic [1:0] reloadReq;

	// Source enables
	logic [1:0] div4_q;
	logic       tick4;
	logic [1:0] sync_q;        // Pin synchroniser
	logic       pinPrev_q;
	logic       pinRise;
	logic       trigArm_q;     // Trigger window open
	logic [1:0] tickIn;
	logic       freeze;

	logic [7:0] count0;
	logic [7:0] count1;
	logic [1:0] running;
	logic [1:0] endPulse;
	logic [1:0] togOut;
	dual_timer_pkg::in_mode_type inMode; // Decoded from mode register

	assign inMode = dual_timer_pkg::in_mode_type'(mode_q[dual_timer_pkg::MODE_INLO +: 2]);

	// Hit decode used for both read and write paths
	function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ref_a);
		isAddr = (a == ref_a);
	endfunction : isAddr

	assign wrAct = hsel && hready && htrans[1] && hwrite;
	assign rdAct = hsel && hready && htrans[1] && !hwrite;

	// Address phase register; zero wait states so always ready
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPend_q  <= 1'b0;
			rdPend_q  <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wrPend_q <= wrAct;
			rdPend_q <= rdAct;
			if (wrAct || rdAct) begin
				addr_q <= haddr;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	// Control: whole byte stored; reload bits also act as pulses
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q  <= dual_timer_pkg::CTRL_RESET;
			mode_q  <= dual_timer_pkg::MODE_RESET;
			load0_q <= 8'h00;
			load1_q <= 8'h00;
			pre0_q  <= 6'h00;
			pre1_q  <= 6'h00;
			mask_q  <= 2'h0;
			pwr_q   <= 2'h0;
		end else if (wrPend_q) begin
			if (isAddr(addr_q, dual_timer_pkg::CTRL_ADDR))  ctrl_q  <= hwdata[7:0];
			if (isAddr(addr_q, dual_timer_pkg::MODE_ADDR))  mode_q  <= hwdata[7:0];
			if (isAddr(addr_q, dual_timer_pkg::LOAD0_ADDR)) load0_q <= hwdata[7:0];
			if (isAddr(addr_q, dual_timer_pkg::LOAD1_ADDR)) load1_q <= hwdata[7:0];
			if (isAddr(addr_q, dual_timer_pkg::PRE0_ADDR))  pre0_q  <= hwdata[5:0];
			if (isAddr(addr_q, dual_timer_pkg::PRE1_ADDR))  pre1_q  <= hwdata[5:0];
			if (isAddr(addr_q, dual_timer_pkg::MASK_ADDR))  mask_q  <= hwdata[1:0];
			if (isAddr(addr_q, dual_timer_pkg::PWR_ADDR))   pwr_q   <= hwdata[1:0];
		end else if (pwr_q[dual_timer_pkg::PWR_HALT] && (stat_q & mask_q) != 2'h0) begin
			pwr_q[dual_timer_pkg::PWR_HALT] <= 1'b0;    // Enabled interrupt wakes
		end
	end

	// Command pulses generated per timer
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cmd
			assign runSet[gi] = wrPend_q && isAddr(addr_q, dual_timer_pkg::CTRL_ADDR);
			assign reloadReq[gi] = runSet[gi] &&
				hwdata[gi*dual_timer_pkg::CTRL_STRIDE + dual_timer_pkg::CTRL_RELOAD];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	// Stop state freezes the whole time base halt does not
	assign freeze = pwr_q[dual_timer_pkg::PWR_STOP];

	// Divide-by-four for the second timer's internal source
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div4_q <= 2'h0;
		end else if (!freeze) begin
			div4_q <= div4_q + 2'h1;
		end
	end
	assign tick4 = (div4_q == dual_timer_pkg::DIV4_LAST) && !freeze;

	// Pin passes two flops before any use
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync_q    <= 2'h0;
			pinPrev_q <= 1'b0;
		end else begin
			sync_q    <= {sync_q[0], extTimerInputLine};
			pinPrev_q <= sync_q[1];
		end
	end
	assign pinRise = sync_q[1] && !pinPrev_q;

	// Trigger window: opens on edge, closes at second timer end in single pass only
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			trigArm_q <= 1'b0;
		end else if (pinRise && (inMode == dual_timer_pkg::IN_RETRIG ||
			(inMode == dual_timer_pkg::IN_TRIG && !trigArm_q))) begin
			trigArm_q <= 1'b1;
		end else if (endPulse[1] &&
			!ctrl_q[dual_timer_pkg::CTRL_STRIDE + dual_timer_pkg::CTRL_CONT]) begin
			trigArm_q <= 1'b0;
		end
	end

	// Source select; first timer internal only, second selectable
	always_comb begin
		tickIn[0] = 1'b1;
		if (mode_q[dual_timer_pkg::MODE_CASC]) begin
			tickIn[1] = endPulse[0];
		end else if (!mode_q[dual_timer_pkg::MODE_SRC1]) begin
			tickIn[1] = tick4;
		end else begin
			case (inMode)
				dual_timer_pkg::IN_CLOCK:  tickIn[1] = pinRise;
				dual_timer_pkg::IN_GATE:   tickIn[1] = tick4 && sync_q[1];
				dual_timer_pkg::IN_RETRIG: tickIn[1] = tick4 && trigArm_q;
				dual_timer_pkg::IN_TRIG:   tickIn[1] = tick4 && trigArm_q;
				default:                   tickIn[1] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Timer channels
	// ----------------------------------------------------------------
	timer_channel u_first (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tickIn    (tickIn[0] && !freeze),
		.runSet    (runSet[0]),
		.runVal    (hwdata[dual_timer_pkg::CTRL_RUN]),
		.reloadReq (reloadReq[0]),
		.contMode  (ctrl_q[dual_timer_pkg::CTRL_CONT]),
		.freeze    (freeze),
		.loadValue (load0_q),
		.preValue  (pre0_q),
		.count     (count0),
		.running   (running[0]),
		.endPulse  (endPulse[0]),
		.toggleOut (togOut[0])
	);

	timer_channel u_second (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tickIn    (tickIn[1]),
		.runSet    (runSet[1]),
		.runVal    (hwdata[dual_timer_pkg::CTRL_STRIDE + dual_timer_pkg::CTRL_RUN]),
		.reloadReq (reloadReq[1]),
		.contMode  (ctrl_q[dual_timer_pkg::CTRL_STRIDE + dual_timer_pkg::CTRL_CONT]),
		.freeze    (freeze),
		.loadValue (load1_q),
		.preValue  (pre1_q),
		.count     (count1),
		.running   (running[1]),
		.endPulse  (endPulse[1]),
		.toggleOut (togOut[1])
	);

	// ----------------------------------------------------------------
	// Status, read data, outputs
	// ----------------------------------------------------------------
	// Sticky events; a new event beats the read-clear
	// Only the bits handed out are cleared, so an event at the address edge survives
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stat_q <= 2'h0;
		end else begin
			stat_q <= ((rdPend_q && isAddr(addr_q, dual_timer_pkg::STAT_ADDR)) ?
				(stat_q & ~rdata_q[1:0]) : stat_q) | endPulse;
		end
	end

	// Read mux registered at address phase; count read leaves timer alone
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (rdAct) begin
			case (haddr)
				dual_timer_pkg::CTRL_ADDR:   rdata_q <= {24'h0, ctrl_q[7:6], running[1],
					ctrl_q[4:1], running[0]};
				dual_timer_pkg::MODE_ADDR:   rdata_q <= {24'h0, mode_q};
				dual_timer_pkg::LOAD0_ADDR:  rdata_q <= {24'h0, load0_q};
				dual_timer_pkg::LOAD1_ADDR:  rdata_q <= {24'h0, load1_q};
				dual_timer_pkg::COUNT0_ADDR: rdata_q <= {24'h0, count0};
				dual_timer_pkg::COUNT1_ADDR: rdata_q <= {24'h0, count1};
				dual_timer_pkg::STAT_ADDR:   rdata_q <= {30'h0, stat_q};
				dual_timer_pkg::MASK_ADDR:   rdata_q <= {30'h0, mask_q};
				dual_timer_pkg::PWR_ADDR:    rdata_q <= {30'h0, pwr_q};
				default:                     rdata_q <= 32'h0000_0000;  // Prescalers hidden
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			firstTimerIrq  <= 1'b0;
			secondTimerIrq <= 1'b0;
			irq            <= 1'b0;
			timerOutputPin <= 1'b0;
			cpuClockEn     <= 1'b1;
		end else begin
			firstTimerIrq  <= endPulse[0];
			secondTimerIrq <= endPulse[1];
			irq            <= ((stat_q | endPulse) & mask_q) != 2'h0;
			cpuClockEn     <= (pwr_q == 2'h0);
			case (dual_timer_pkg::out_sel_type'(mode_q[dual_timer_pkg::MODE_OUTLO +: 2]))
				dual_timer_pkg::OUT_FIRST:  timerOutputPin <= togOut[0];
				dual_timer_pkg::OUT_SECOND: timerOutputPin <= togOut[1];
				dual_timer_pkg::OUT_CLOCK:  timerOutputPin <= div4_q[1];
				default:                    timerOutputPin <= 1'b0;
			endcase
		end
	end

endmodule : dual_prescaled_down_counters

// ==== hw/dual_timer_pkg.sv ====
package dual_timer_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR   = 8'h00; // Start/restart/mode bits
	localparam logic [7:0] MODE_ADDR   = 8'h04; // Input and output selects
	localparam logic [7:0] LOAD0_ADDR  = 8'h08; // First timer initial value
	localparam logic [7:0] LOAD1_ADDR  = 8'h0c; // Second timer initial value
	localparam logic [7:0] PRE0_ADDR   = 8'h10; // First prescale ratio
	localparam logic [7:0] PRE1_ADDR   = 8'h14; // Second prescale ratio
	localparam logic [7:0] COUNT0_ADDR = 8'h18; // First current count
	localparam logic [7:0] COUNT1_ADDR = 8'h1c; // Second current count
	localparam logic [7:0] STAT_ADDR   = 8'h20; // Sticky events, read clears
	localparam logic [7:0] MASK_ADDR   = 8'h24; // Interrupt mask
	localparam logic [7:0] PWR_ADDR    = 8'h28; // Halt/stop state

	// ----------------------------------------------------------------
	// Control register fields (per timer i: base 4*i)
	// ----------------------------------------------------------------
	localparam int CTRL_RUN     = 0; // Write 1 run, 0 stop (resume keeps count)
	localparam int CTRL_RELOAD  = 1; // Write 1: load initial value (pulse)
	localparam int CTRL_CONT    = 2; // 1 modulo-n, 0 single pass
	localparam int CTRL_STRIDE  = 4; // Field stride between timers

	// Mode register fields
	localparam int MODE_SRC1    = 0; // Second source: 0 internal, 1 external
	localparam int MODE_CASC    = 1; // Cascade first into second
	localparam int MODE_INLO    = 2; // Input mode low bit (2 bits)
	localparam int MODE_OUTLO   = 4; // Output select low bit (2 bits)

	// Power register fields
	localparam int PWR_HALT     = 0;
	localparam int PWR_STOP     = 1;

	// Input line usage
	typedef enum logic [1:0] {
		IN_CLOCK,   // External clock
		IN_RETRIG,  // Retriggerable trigger
		IN_TRIG,    // Non-retriggerable trigger
		IN_GATE     // Gate on internal clock
	} in_mode_type;

	// Output line selection
	typedef enum logic [1:0] {
		OUT_FIRST,
		OUT_SECOND,
		OUT_CLOCK,
		OUT_OFF
	} out_sel_type;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int COUNT_W = 8;
	localparam int PRE_W   = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [1:0] DIV4_LAST  = 2'h3; // Divide-by-four terminal
	localparam logic [1:0] EVT_FIRST  = 2'h1; // Status bit of first timer
	localparam logic [1:0] EVT_SECOND = 2'h2; // Status bit of second timer

endpackage : dual_timer_pkg

// ==== hw/timer_channel.sv ====
// ----------------------------------------------------------------
// One prescaler plus 8-bit down counter
// ----------------------------------------------------------------
module timer_channel (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       tickIn,      // Source clock enable
	input  wire logic       runSet,      // Write strobe with run value
	input  wire logic       runVal,
	input  wire logic       reloadReq,   // Restart from initial value
	input  wire logic       contMode,    // Modulo-n when high
	input  wire logic       freeze,      // Stop state holds prescaler and count; reload and run writes still act
	input  wire logic [7:0] loadValue,
	input  wire logic [5:0] preValue,
	// Results
	output logic      [7:0] count,
	output logic            running,
	output logic            endPulse,    // One cycle at end of count
	output logic            toggleOut    // Timer output square wave
);

	logic [5:0] preCnt_q;   // Prescaler, never readable
	logic [7:0] count_q;
	logic       run_q;
	logic       end_q;
	logic       tog_q;
	logic       preTick;

	assign count     = count_q;
	assign running   = run_q;
	assign endPulse  = end_q;
	assign toggleOut = tog_q;

	// Terminal of prescaler; ratio zero wraps through 64 states
	assign preTick = tickIn && run_q && !freeze && (preCnt_q == 6'h01);

	// Prescaler counts down from ratio, dividing 1..64
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			preCnt_q <= 6'h00;
		end else if (reloadReq || !run_q) begin
			preCnt_q <= preValue;
		end else if (tickIn && !freeze) begin
			preCnt_q <= (preCnt_q == 6'h01) ? preValue : preCnt_q - 6'h01;
		end
	end

	// Counter; load of zero gives 256 steps via wrap
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_q <= 8'h00;
		end else if (reloadReq) begin
			count_q <= loadValue;
		end else if (preTick) begin
			if (count_q == 8'h01) begin
				count_q <= contMode ? loadValue : 8'h00;
			end else begin
				count_q <= count_q - 8'h01;
			end
		end
	end

	// Run state: set by software, cleared at single-pass end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
		end else if (runSet) begin
			run_q <= runVal;
		end else if (preTick && count_q == 8'h01 && !contMode) begin
			run_q <= 1'b0;
		end
	end

	// End-of-count pulse and output toggle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			end_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			end_q <= preTick && count_q == 8'h01;
			if (preTick && count_q == 8'h01) begin
				tog_q <= !tog_q;
			end
		end
	end

endmodule : timer_channel

// ==== dv/ext_clock_model.sv ====
// ----------------------------------------------------------------
// External timer input source
// ----------------------------------------------------------------
module ext_clock_model #(
	parameter int HALF = 3 // Cycles per half period
) (
	// Clock
	input  wire logic mclk,
	// Control
	input  wire logic enable,
	// Pin
	output logic      line
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt_q; // Half period counter

	// Defined level from time zero
	initial begin
		line = 1'b0;
		cnt_q = 0;
	end

	// Square wave only while enabled, parked low otherwise
	always @(posedge mclk) begin
		if (!enable) begin
			line  <= 1'b0;
			cnt_q <= 0;
		end else if (cnt_q == HALF - 1) begin
			line  <= ~line;
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule : ext_clock_model

// ==== dv/dual_timer_monitor.sv ====
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module dual_timer_monitor (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Bus
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Pins and interrupts
	input  wire logic        timerOutputPin,
	input  wire logic        firstTimerIrq,
	input  wire logic        secondTimerIrq,
	input  wire logic        irq,
	input  wire logic        cpuClockEn
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       wrPend_q; // Write data phase
	logic       rdPend_q; // Read data phase
	logic [7:0] addr_q;   // Address taken
	logic [1:0] mask_q;   // Mask shadow
	logic       stop_q;   // Stop bit shadow
	logic [1:0] outSel_q; // Output select shadow
	logic [2:0] selAge_q; // Cycles since select change, saturating

	// Shadow registers decoded from bus traffic
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			addr_q   <= 8'h00;
			mask_q   <= 2'h0;
			stop_q   <= 1'b0;
			outSel_q <= 2'h0;
			selAge_q <= 3'h0;
		end else begin
			wrPend_q <= hsel & hready & htrans[1] & hwrite;
			rdPend_q <= hsel & hready & htrans[1] & ~hwrite;
			addr_q   <= haddr;
			if (wrPend_q && addr_q == dual_timer_pkg::MASK_ADDR) begin
				mask_q <= hwdata[1:0];
			end
			if (wrPend_q && addr_q == dual_timer_pkg::PWR_ADDR) begin
				stop_q <= hwdata[1];
			end
			if (wrPend_q && addr_q == dual_timer_pkg::MODE_ADDR) begin
				outSel_q <= hwdata[5:4];
			end
			// Restart age so pin checks skip the switch-over
			if (wrPend_q && addr_q == dual_timer_pkg::MODE_ADDR && hwdata[5:4] != outSel_q) begin
				selAge_q <= 3'h0;
			end else if (selAge_q != 3'h7) begin
				selAge_q <= selAge_q + 3'h1;
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	pre_hidden_a: assert property (rdPend_q && (addr_q == dual_timer_pkg::PRE0_ADDR ||
		addr_q == dual_timer_pkg::PRE1_ADDR) |-> hrdata == 32'h0) else $error("prescale readable");
	stop_freeze_a: assert property (stop_q && $past(stop_q) && $past(stop_q, 3)
		|-> !firstTimerIrq && !secondTimerIrq) else $error("count in stop");
	stop_sleep_a: assert property (stop_q && $past(stop_q) |-> !cpuClockEn)
		else $error("clock on in stop");
	halt_sleep_a: assert property (wrPend_q && addr_q == dual_timer_pkg::PWR_ADDR &&
		hwdata[0] && mask_q == 2'h0 |-> ##[1:2] !cpuClockEn) else $error("no halt");
	wake_irq_a: assert property (irq && !cpuClockEn && !stop_q |-> ##[1:3] cpuClockEn)
		else $error("no wake");
	irq_mask_a: assert property (firstTimerIrq && mask_q[0] |-> ##[0:1] irq)
		else $error("irq missing");
	irq_quiet_a: assert property (mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq)
		else $error("masked irq");
	pin_low_a: assert property (selAge_q == 3'h7 && outSel_q == 2'h3 |-> !timerOutputPin)
		else $error("pin not low");
	clock_div_a: assert property (selAge_q == 3'h7 && outSel_q == 2'h2
		|-> timerOutputPin != $past(timerOutputPin, 2)) else $error("pin not clock/4");

	cover property (firstTimerIrq);
	cover property (secondTimerIrq);
	cover property (!cpuClockEn);
endmodule : dual_timer_monitor

bind dual_prescaled_down_counters dual_timer_monitor mon_u (
	.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.timerOutputPin(timerOutputPin), .firstTimerIrq(firstTimerIrq),
	.secondTimerIrq(secondTimerIrq), .irq(irq), .cpuClockEn(cpuClockEn)
);

// ==== dv/tb_top.sv ====
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %0h want %0h", $time, g, e); end end

// ----------------------------------------------------------------
// Testbench top
// ----------------------------------------------------------------
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk, rst_n, hsel, hwrite, hready, extEn;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, a, b, c;
	logic        hreadyout, hresp, pin, ext_irq_a, ext_irq_b, irq, cpuOn, x;
	wire         extLine;                   // Partner-driven input pin
	int          mismatches, checkCount, n;
	int          preT[5]  = '{1, 3, 0, 1, 2}; // Zero means divide by 64
	int          loadT[5] = '{3, 5, 2, 0, 1}; // Zero means 256
	int          expT[5]  = '{3, 15, 128, 256, 2};

	dual_prescaled_down_counters dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.extTimerInputLine(extLine), .timerOutputPin(pin), .firstTimerIrq(ext_irq_a),
		.secondTimerIrq(ext_irq_b), .irq(irq), .cpuClockEn(cpuOn));
	ext_clock_model #(.HALF(3)) pin_u (.mclk(mclk), .enable(extEn), .line(extLine));

	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// One AHB-Lite single transfer, waits on hreadyout
	task automatic busXfer(input logic wr, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= ad;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : busXfer

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] q;
		busXfer(1'b1, ad, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [31:0] q);
		busXfer(1'b0, ad, 32'h0, q);
	endtask : rd

	// Skip to one end pulse, then count cycles to the next
	task automatic gapOf(input logic sec, input int lim, output int g);
		int k;
		k = 0;
		g = 0;
		do begin @(posedge mclk); k++; end while ((sec ? ext_irq_b : ext_irq_a) !== 1'b1 && k < lim);
		do begin @(posedge mclk); g++; end while ((sec ? ext_irq_b : ext_irq_a) !== 1'b1 && g < lim);
	endtask : gapOf

	// Verdict and end of run
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : endOfTest

	// Watchdog, well above the expected few thousand cycles
	initial begin
		repeat (30000) @(posedge mclk);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		endOfTest();
	end

	// Main sequence
	initial begin
		{hsel, hwrite, extEn, rst_n} = 4'h0;
		hready = 1'b1;
		haddr = 8'h00;
		htrans = 2'h0;
		hsize = 3'h0;
		hwdata = 32'h0;
		mismatches = 0;
		checkCount = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		`CHK({hreadyout, hresp}, 2'h2)
		rd(dual_timer_pkg::CTRL_ADDR, a);  `CHK(a, 32'h0)
		rd(dual_timer_pkg::MODE_ADDR, a);  `CHK(a, 32'h0)
		wr(dual_timer_pkg::PRE0_ADDR, 32'h3f);
		rd(dual_timer_pkg::PRE0_ADDR, a);  `CHK(a, 32'h0)
		rd(8'h3c, a);                      `CHK(a, 32'h0)
		// Period is prescale times load, zero codes at full range
		for (int i = 0; i < 5; i++) begin
			wr(dual_timer_pkg::PRE0_ADDR, 32'(preT[i]));
			wr(dual_timer_pkg::LOAD0_ADDR, 32'(loadT[i]));
			wr(dual_timer_pkg::CTRL_ADDR, 32'h07);
			gapOf(1'b0, 600, n);             `CHK(n, expT[i])
		end
		// Single pass ends at zero and drops run
		wr(dual_timer_pkg::LOAD0_ADDR, 32'h03);
		wr(dual_timer_pkg::PRE0_ADDR, 32'h01);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h03);
		repeat (20) @(posedge mclk);
		rd(dual_timer_pkg::COUNT0_ADDR, a); `CHK(a, 32'h0)
		rd(dual_timer_pkg::CTRL_ADDR, a);   `CHK(a[0], 1'b0)
		gapOf(1'b0, 40, n);                 `CHK(n, 40)
		// Stop holds, resume continues, restart reloads
		wr(dual_timer_pkg::LOAD0_ADDR, 32'hc8);
		wr(dual_timer_pkg::PRE0_ADDR, 32'h00);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h07);
		repeat (200) @(posedge mclk);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h04);
		rd(dual_timer_pkg::COUNT0_ADDR, a);
		repeat (100) @(posedge mclk);
		rd(dual_timer_pkg::COUNT0_ADDR, b); `CHK(b, a)
		`CHK(a < 32'hc8, 1'b1)
		wr(dual_timer_pkg::CTRL_ADDR, 32'h05);
		repeat (200) @(posedge mclk);
		rd(dual_timer_pkg::COUNT0_ADDR, c); `CHK(c < a, 1'b1)
		wr(dual_timer_pkg::CTRL_ADDR, 32'h07);
		rd(dual_timer_pkg::COUNT0_ADDR, c); `CHK(c >= 32'hc7, 1'b1)
		// Stop state freezes, halt keeps counting
		wr(dual_timer_pkg::PWR_ADDR, 32'h2);
		rd(dual_timer_pkg::COUNT0_ADDR, a);
		repeat (150) @(posedge mclk);
		rd(dual_timer_pkg::COUNT0_ADDR, b); `CHK(b, a)
		`CHK(cpuOn, 1'b0)
		wr(dual_timer_pkg::PWR_ADDR, 32'h1);
		repeat (150) @(posedge mclk);
		rd(dual_timer_pkg::COUNT0_ADDR, b); `CHK(b < a, 1'b1)
		`CHK(cpuOn, 1'b0)
		// Unmasked event raises irq and wakes
		wr(dual_timer_pkg::LOAD0_ADDR, 32'h04);
		wr(dual_timer_pkg::PRE0_ADDR, 32'h01);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h07);
		wr(dual_timer_pkg::MASK_ADDR, 32'(dual_timer_pkg::EVT_FIRST));
		repeat (10) @(posedge mclk);
		`CHK(cpuOn, 1'b1)
		`CHK(irq, 1'b1)
		wr(dual_timer_pkg::CTRL_ADDR, 32'h00);
		rd(dual_timer_pkg::STAT_ADDR, a);   `CHK(a[0], 1'b1)
		rd(dual_timer_pkg::STAT_ADDR, a);   `CHK(a, 32'h0)
		repeat (3) @(posedge mclk);
		`CHK(irq, 1'b0)
		wr(dual_timer_pkg::CTRL_ADDR, 32'h07);
		wr(dual_timer_pkg::MASK_ADDR, 32'h0);
		repeat (10) @(posedge mclk);
		`CHK(irq, 1'b0)
		rd(dual_timer_pkg::STAT_ADDR, a);   `CHK(a[0], 1'b1)
		// Second timer from clock/4, then from the pin
		wr(dual_timer_pkg::CTRL_ADDR, 32'h00);
		wr(dual_timer_pkg::PRE1_ADDR, 32'h02);
		wr(dual_timer_pkg::LOAD1_ADDR, 32'h03);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h70);
		gapOf(1'b1, 600, n);                `CHK(n, 24)
		wr(dual_timer_pkg::MODE_ADDR, 32'h01);
		extEn <= 1'b1;
		wr(dual_timer_pkg::PRE1_ADDR, 32'h01);
		wr(dual_timer_pkg::LOAD1_ADDR, 32'h04);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h70);
		gapOf(1'b1, 600, n);                `CHK(n, 24)
		// Output select: parked low, then clock/4
		wr(dual_timer_pkg::MODE_ADDR, 32'h30);
		repeat (10) @(posedge mclk);
		`CHK(pin, 1'b0)
		wr(dual_timer_pkg::MODE_ADDR, 32'h20);
		repeat (10) @(posedge mclk);
		x = pin;
		repeat (2) @(posedge mclk);
		`CHK(pin, ~x)
		// Cascade: first timer end pulses clock the second
		wr(dual_timer_pkg::LOAD0_ADDR, 32'h02);
		wr(dual_timer_pkg::PRE0_ADDR, 32'h01);
		wr(dual_timer_pkg::LOAD1_ADDR, 32'h03);
		wr(dual_timer_pkg::PRE1_ADDR, 32'h01);
		wr(dual_timer_pkg::MODE_ADDR, 32'h02);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h77);
		gapOf(1'b1, 600, n);                `CHK(n, 6)
		// Gate mode with the pin held low lets nothing through
		extEn <= 1'b0;
		wr(dual_timer_pkg::MODE_ADDR, 32'h0d);
		wr(dual_timer_pkg::CTRL_ADDR, 32'h70);
		gapOf(1'b1, 40, n);                 `CHK(n, 40)
		endOfTest();
	end
endmodule : tb_top
